// ### shared/vfx_params.svh
`ifndef VFX_PARAMS_SVH
`define VFX_PARAMS_SVH
// Operation
// - each draw command runs input assembly: generate indices, gather vertex data
// - random mode reads 8, 16 or 32 bit index list entries to address buffers
// - linear access mode reads buffers in consecutive order without an index list
// - cut termination only for lists, strips, adjacency, reverse, continued, patches
// - buffer is array of fixed-stride structures, vertex or instance number selects
// - computed buffer index compared against the buffer index limit (here only in random mode and for per-instance buffers)
// - reads outside buffer extent return zero data
// - linear per-vertex buffers end at last byte address plus one
// - element layout command sets source and placement of vertex entry data
// - each active element yields up to four contiguous 32-bit components
// - linear mode vertex identifier restarts at zero each instance
`define VFX_AW        32
`define VFX_NVB       2
`define VFX_SELW      1
`define VFX_FDEPTH    8
`define VFX_FW        34
`define VFX_IW8       2'b00
`define VFX_IW16      2'b01
`define VFX_IW32      2'b10
`define VFX_MSK8      32'h0000_00ff
`define VFX_MSK16     32'h0000_ffff
`define VFX_MSK32     32'hffff_ffff
`define VFX_SRC_MEM   2'b00
`define VFX_SRC_ZERO  2'b01
`define VFX_SRC_VID   2'b10
`define VFX_SRC_IID   2'b11
`define VFX_ZERO32    32'h0000_0000
`define VFX_INC32     32'h0000_0001
`define VFX_INC33     33'h0_0000_0001
`define VFX_WB_M1     33'h0_0000_0003
`define VFX_NCOMP_MAX 3'h4
`define VFX_NC_ONE    3'h1
`define VFX_CP_ONE    2'h1
`define VFX_CP_ZERO   2'h0
`define VFX_T_POINTLIST   6'h01
`define VFX_T_LINELIST    6'h02
`define VFX_T_LINESTRIP   6'h03
`define VFX_T_TRILIST     6'h04
`define VFX_T_TRISTRIP    6'h05
`define VFX_T_TRISTRIP_RV 6'h06
`define VFX_T_LINELIST_A  6'h09
`define VFX_T_LINESTRIP_A 6'h0a
`define VFX_T_TRILIST_A   6'h0b
`define VFX_T_TRISTRIP_A  6'h0c
`define VFX_T_POINT_BF    6'h13
`define VFX_T_LSTRIP_CONT 6'h14
`define VFX_T_LSTRIP_BF   6'h15
`define VFX_T_LSTRIP_CBF  6'h16
`define VFX_T_PATCH_LO    6'h20
`endif

// ### shared/vfx_pkg.sv
package vfx_pkg;
    typedef enum logic [6:0] {
        VFX_IDLE = 7'h01,
        VFX_IDXR = 7'h02,
        VFX_IDXW = 7'h04,
        VFX_COMP = 7'h08,
        VFX_MREQ = 7'h10,
        VFX_MWAIT = 7'h20,
        VFX_PUSH = 7'h40
    } vfx_state_t;
    typedef logic [31:0] vfx_word_t;
endpackage

// ### shared/vfx_stream_if.sv
`timescale 1ns/1ps
interface vfx_stream_if #(parameter int W = 34);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### hw/vfx_fifo.sv
`timescale 1ns/1ps
module vfx_fifo #(
    parameter int W = 34,
    parameter int D = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    vfx_stream_if.snk         s,
    output logic              o_valid,
    input  wire logic         o_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d;
    logic [W-1:0]  od_q, od_d;
    logic          wr, rd;

    // ready only from the count register, so the source sees true back-pressure
    assign s.ready = (cnt_q != (AW+1)'(D));

    always_comb begin
        wr = s.valid && s.ready;
        rd = (!ov_q || o_ready) && (cnt_q != '0);
        wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        ov_d = ov_q;
        od_d = od_q;
        if (rd) begin
            ov_d = 1'b1;
            od_d = mem_q[rp_q];
        end else if (o_ready) begin
            ov_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr) begin
            mem_q[wp_q] <= s.data;
        end
        if (!rst_b) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    assign o_valid = ov_q;
    assign o_data  = od_q;

    c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_b) !s.ready);
endmodule // vfx_fifo

// ### hw/vfx_fetch.sv
`timescale 1ns/1ps
`include "vfx_params.svh"
module vfx_fetch
    import vfx_pkg::*;
(
    input  wire logic                             clk_sys,
    input  wire logic                             rst_b,
    input  wire logic                             cmd_valid,
    output logic                                  cmd_ready,
    input  wire logic                             cmd_random,
    input  wire logic [5:0]                       cmd_topo,
    input  wire logic [31:0]                      cmd_start,
    input  wire logic [31:0]                      cmd_vcount,
    input  wire logic [31:0]                      cmd_icount,
    input  wire logic [31:0]                      ib_base,
    input  wire logic [1:0]                       ib_width,
    input  wire logic                             ib_cut_en,
    input  wire logic [`VFX_NVB-1:0][31:0]        vb_base,
    input  wire logic [`VFX_NVB-1:0][31:0]        vb_stride,
    input  wire logic [`VFX_NVB-1:0]              vb_inst,
    input  wire logic [`VFX_NVB-1:0][31:0]        vb_limit,
    input  wire logic [`VFX_NVB-1:0][31:0]        vb_last,
    input  wire logic                             el_load,
    input  wire logic [`VFX_SELW-1:0]             el_vb_sel,
    input  wire logic [31:0]                      el_offset,
    input  wire logic [2:0]                       el_ncomp,
    input  wire logic [3:0][1:0]                  el_src,
    output logic                                  mem_req,
    output logic [31:0]                           mem_addr,
    input  wire logic                             mem_gnt,
    input  wire logic                             mem_rvalid,
    input  wire logic [31:0]                      mem_rdata,
    output logic                                  out_valid,
    input  wire logic                             out_ready,
    output logic [31:0]                           out_data,
    output logic                                  out_last,
    output logic                                  out_cut,
    output logic                                  busy,
    output logic                                  cut_topo_err
);
    vfx_state_t st_q, st_d;
    logic rnd_q, rnd_d, cen_q, cen_d, rdy_q, rdy_d, err_q, err_d;
    logic [1:0] iw_q, iw_d;
    vfx_word_t vc_q, vc_d, ic_q, ic_d, sp_q, sp_d, v_q, v_d, i_q, i_d;
    vfx_word_t idx_q, idx_d, wd_q, wd_d, ma_q, ma_d;
    logic wl_q, wl_d, wc_q, wc_d, mr_q, mr_d;
    logic [1:0] cp_q, cp_d;
    logic [`VFX_SELW-1:0] es_q, es_d;
    vfx_word_t eo_q, eo_d;
    logic [2:0] en_q, en_d;
    logic [3:0][1:0] ec_q, ec_d;
    vfx_word_t vnum, vid, ib_ba, ib_msk, ival;
    logic [31:0] addr_g [`VFX_NVB];
    logic [`VFX_NVB-1:0] inb_g;
    logic take, adv, sup, cut_hit;
    logic [1:0] src;
    logic [33:0] fd;
    logic busy_q, busy_d;

    vfx_stream_if #(.W(`VFX_FW)) fs ();

    function automatic logic cut_ok(input logic [5:0] t);
        case (t)
            `VFX_T_POINTLIST, `VFX_T_LINELIST, `VFX_T_LINESTRIP, `VFX_T_TRILIST,
            `VFX_T_TRISTRIP, `VFX_T_TRISTRIP_RV, `VFX_T_LINELIST_A, `VFX_T_LINESTRIP_A,
            `VFX_T_TRILIST_A, `VFX_T_TRISTRIP_A, `VFX_T_POINT_BF, `VFX_T_LSTRIP_CONT,
            `VFX_T_LSTRIP_BF, `VFX_T_LSTRIP_CBF: cut_ok = 1'b1;
            default: cut_ok = (t >= `VFX_T_PATCH_LO);
        endcase
    endfunction

    // vertex number and identifier per access mode
    assign vnum = rnd_q ? idx_q : sp_q + v_q;
    assign vid  = rnd_q ? idx_q : v_q;

    genvar g;
    generate
        for (g = 0; g < `VFX_NVB; g++) begin : gvb
            logic [63:0] prod;
            logic [32:0] endx;
            vfx_word_t   num;
            assign num  = vb_inst[g] ? i_q : vnum;
            assign prod = 64'(num) * 64'(vb_stride[g]);
            assign addr_g[g] = vb_base[g] + prod[31:0] + eo_q + {28'h000_0000, cp_q, 2'b00};
            assign endx = {1'b0, vb_last[g]} + `VFX_INC33;
            // linear per-vertex: end address bound; otherwise index limit
            assign inb_g[g] = (!vb_inst[g] && !rnd_q)
                ? (({1'b0, addr_g[g]} + `VFX_WB_M1) < endx)
                : (num <= vb_limit[g]);
        end
    endgenerate

    always_comb begin
        case (iw_q)
            `VFX_IW8:  ib_msk = `VFX_MSK8;
            `VFX_IW16: ib_msk = `VFX_MSK16;
            default:   ib_msk = `VFX_MSK32;
        endcase
        ib_ba = ib_base + ((sp_q + v_q) << iw_q);
        ival  = (mem_rdata >> {ib_ba[1:0], 3'b000}) & ib_msk;
    end

    always_comb begin
        st_d = st_q; rnd_d = rnd_q; cen_d = cen_q; iw_d = iw_q;
        vc_d = vc_q; ic_d = ic_q; sp_d = sp_q; v_d = v_q; i_d = i_q;
        idx_d = idx_q; wd_d = wd_q; wl_d = wl_q; wc_d = wc_q;
        mr_d = mr_q; ma_d = ma_q; cp_d = cp_q; err_d = 1'b0;
        es_d = es_q; eo_d = eo_q; en_d = en_q; ec_d = ec_q;
        adv = 1'b0;
        src = ec_q[cp_q];
        sup = cut_ok(cmd_topo);
        cut_hit = cen_q && (ival == ib_msk);
        take = cmd_valid && rdy_q;
        rdy_d = (st_q == VFX_IDLE) && !take;
        if (el_load && st_q == VFX_IDLE) begin
            es_d = el_vb_sel;
            eo_d = el_offset;
            en_d = (el_ncomp > `VFX_NCOMP_MAX) ? `VFX_NCOMP_MAX : el_ncomp;
            ec_d = el_src;
        end
        case (st_q)
            VFX_IDLE: if (take) begin
                if (ib_cut_en && !sup) begin
                    err_d = 1'b1; // refused, nothing fetched
                end else if (cmd_vcount != `VFX_ZERO32 && cmd_icount != `VFX_ZERO32) begin
                    rnd_d = cmd_random; cen_d = ib_cut_en; iw_d = ib_width;
                    vc_d = cmd_vcount; ic_d = cmd_icount; sp_d = cmd_start;
                    v_d = `VFX_ZERO32; i_d = `VFX_ZERO32; cp_d = `VFX_CP_ZERO;
                    st_d = cmd_random ? VFX_IDXR : VFX_COMP;
                end
            end
            VFX_IDXR: begin
                mr_d = 1'b1;
                ma_d = {ib_ba[31:2], 2'b00};
                if (mr_q && mem_gnt) begin
                    mr_d = 1'b0;
                    st_d = VFX_IDXW;
                end
            end
            VFX_IDXW: if (mem_rvalid) begin
                idx_d = ival;
                if (cut_hit) begin
                    wd_d = `VFX_ZERO32; wc_d = 1'b1; wl_d = 1'b1;
                    st_d = VFX_PUSH;
                end else begin
                    st_d = VFX_COMP;
                end
            end
            VFX_COMP: begin
                wc_d = 1'b0;
                wl_d = ({1'b0, cp_q} == en_q - `VFX_NC_ONE);
                if (en_q == 3'h0) begin
                    adv = 1'b1;
                end else if (src == `VFX_SRC_MEM && inb_g[es_q]) begin
                    st_d = VFX_MREQ;
                end else begin
                    case (src)
                        `VFX_SRC_VID: wd_d = vid;
                        `VFX_SRC_IID: wd_d = i_q;
                        default:      wd_d = `VFX_ZERO32;
                    endcase
                    st_d = VFX_PUSH;
                end
            end
            VFX_MREQ: begin
                mr_d = 1'b1;
                ma_d = addr_g[es_q];
                if (mr_q && mem_gnt) begin
                    mr_d = 1'b0;
                    st_d = VFX_MWAIT;
                end
            end
            VFX_MWAIT: if (mem_rvalid) begin
                wd_d = mem_rdata;
                st_d = VFX_PUSH;
            end
            VFX_PUSH: if (fs.ready) begin
                if (wc_q || wl_q) begin
                    adv = 1'b1;
                end else begin
                    cp_d = cp_q + `VFX_CP_ONE;
                    st_d = VFX_COMP;
                end
            end
            default: st_d = VFX_IDLE;
        endcase
        if (adv) begin
            cp_d = `VFX_CP_ZERO;
            st_d = rnd_q ? VFX_IDXR : VFX_COMP;
            if (v_q == vc_q - `VFX_INC32) begin
                v_d = `VFX_ZERO32;
                i_d = i_q + `VFX_INC32;
                if (i_q == ic_q - `VFX_INC32) begin
                    st_d = VFX_IDLE;
                end
            end else begin
                v_d = v_q + `VFX_INC32;
            end
        end
        busy_d = (st_d != VFX_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q <= VFX_IDLE; rnd_q <= 1'b0; cen_q <= 1'b0; iw_q <= `VFX_IW8;
            rdy_q <= 1'b0; err_q <= 1'b0; vc_q <= '0; ic_q <= '0; sp_q <= '0;
            v_q <= '0; i_q <= '0; idx_q <= '0; wd_q <= '0; wl_q <= 1'b0;
            wc_q <= 1'b0; mr_q <= 1'b0; ma_q <= '0; cp_q <= '0;
            es_q <= '0; eo_q <= '0; en_q <= '0; ec_q <= '0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d; rnd_q <= rnd_d; cen_q <= cen_d; iw_q <= iw_d;
            rdy_q <= rdy_d; err_q <= err_d; vc_q <= vc_d; ic_q <= ic_d; sp_q <= sp_d;
            v_q <= v_d; i_q <= i_d; idx_q <= idx_d; wd_q <= wd_d; wl_q <= wl_d;
            wc_q <= wc_d; mr_q <= mr_d; ma_q <= ma_d; cp_q <= cp_d;
            es_q <= es_d; eo_q <= eo_d; en_q <= en_d; ec_q <= ec_d;
            busy_q <= busy_d;
        end
    end

    // pushes stall here while the fifo is full
    assign fs.valid = (st_q == VFX_PUSH);
    assign fs.data  = {wc_q, wl_q, wd_q};

    vfx_fifo #(.W(`VFX_FW), .D(`VFX_FDEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .s       (fs),
        .o_valid (out_valid),
        .o_ready (out_ready),
        .o_data  (fd)
    );

    assign out_data     = fd[31:0];
    assign out_last     = fd[32];
    assign out_cut      = fd[33];
    assign cmd_ready    = rdy_q;
    assign busy         = busy_q;
    assign cut_topo_err = err_q;
    assign mem_req      = mr_q;
    assign mem_addr     = ma_q;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_draw_starts: assert property (take && !(ib_cut_en && !sup) && cmd_vcount != 0
        && cmd_icount != 0 |=> st_q != VFX_IDLE)
        else $error("accepted draw did not start");
    a_idx_aligned: assert property (mem_req && st_q == VFX_IDXR |-> mem_addr[1:0] == 2'b00
        && rnd_q)
        else $error("index fetch misaligned or in linear mode");
    a_linear_noidx: assert property (!rnd_q |-> !(st_q inside {VFX_IDXR, VFX_IDXW}))
        else $error("linear mode touched the index list");
    a_topo_refuse: assert property (take && ib_cut_en && !sup |=> cut_topo_err
        && st_q == VFX_IDLE ##1 !cut_topo_err)
        else $error("unsupported cut topology not refused");
    a_cut_marker: assert property (st_q == VFX_IDXW && mem_rvalid && cut_hit
        |=> st_q == VFX_PUSH && fs.data[33] && fs.data[31:0] == 0)
        else $error("cut index not turned into marker");
    a_limit_check: assert property (st_q == VFX_COMP && (vb_inst[es_q] || rnd_q)
        && (vb_inst[es_q] ? i_q : vnum) > vb_limit[es_q] |-> !inb_g[es_q])
        else $error("index beyond limit treated as inside");
    a_oob_zero: assert property (st_q == VFX_COMP && en_q != 0 && src == `VFX_SRC_MEM
        && !inb_g[es_q] |=> st_q == VFX_PUSH && wd_q == 0)
        else $error("out of range read not zero");
    a_end_bound: assert property (st_q == VFX_COMP && !rnd_q && !vb_inst[es_q]
        && {1'b0, addr_g[es_q]} + `VFX_WB_M1 > {1'b0, vb_last[es_q]} |-> !inb_g[es_q])
        else $error("read past end address allowed");
    a_comp_count: assert property (st_q == VFX_PUSH && fs.ready && !wc_q && !wl_q
        |=> st_q == VFX_COMP && cp_q == $past(cp_q) + `VFX_CP_ONE
        && en_q <= `VFX_NCOMP_MAX)
        else $error("component stepping wrong");
    a_vid_restart: assert property (!rnd_q && i_q != $past(i_q) && st_q != VFX_IDLE
        |-> vid == 0)
        else $error("vertex identifier not reset per instance");
    a_idx_zext: assert property (st_q == VFX_IDXW && mem_rvalid && iw_q == `VFX_IW8
        |=> idx_q[31:8] == 24'h0)
        else $error("index not zero-extended");

    c_random_draw: cover property (st_q == VFX_IDXW && mem_rvalid ##[1:20] st_q == VFX_IDLE);
    c_cut_seen:    cover property (fs.valid && fs.ready && fs.data[33]);
    c_oob_read:    cover property (st_q == VFX_COMP && src == `VFX_SRC_MEM && !inb_g[es_q]);
    c_refused:     cover property (cut_topo_err);
endmodule // vfx_fetch

// ### tb/vfx_mem_model.sv
`timescale 1ns/1ps
module vfx_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_gnt,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata
);
    logic [31:0] a_q;
    logic        pend_q;
    int          wait_q;
    // 16-word index list at 0x1000, word 7 all ones
    function automatic logic [31:0] word_at(input logic [31:0] a);
        if (a[31:6] == 26'h000_0040)
            return (a[5:2] == 4'h7) ? 32'hffff_ffff : {28'h000_0000, a[5:2]};
        return a ^ 32'ha5a5_0000;
    endfunction
    // released data lines alternate each cycle between the last word and its inverse
    always_ff @(posedge clk_sys) begin
        mem_gnt <= 1'b0;
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!rst_b) begin
            pend_q <= 1'b0;
            wait_q <= 0;
            mem_rdata <= 32'h0000_0000;
        end else if (pend_q) begin
            if (wait_q == 0) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= word_at(a_q);
                pend_q <= 1'b0;
                wait_q <= slow ? 2 : 0;
            end else
                wait_q <= wait_q - 1;
        end else if (mem_req && mem_gnt) begin
            a_q <= mem_addr;
            pend_q <= 1'b1;
            wait_q <= slow ? 3 : 0;
        end else if (mem_req) begin
            if (wait_q == 0)
                mem_gnt <= 1'b1;
            else
                wait_q <= wait_q - 1;
        end
    end
endmodule // vfx_mem_model

// ### tb/vertex_fetch_index_buffer_access_tb_top.sv
`timescale 1ns/1ps
`include "vfx_params.svh"
module vertex_fetch_index_buffer_access_tb_top;
    typedef struct {
        bit         rnd, cut, sel, err;
        logic [5:0] topo;
        logic [1:0] w;
        int         start, vc, ic, nc;
        logic [7:0] src;
    } vfx_row_t;
    logic        clk_sys, rst_b, cmd_valid, cmd_ready, cmd_random, ib_cut_en, el_load, slow;
    logic        mem_req, mem_gnt, mem_rvalid, out_valid, out_ready, out_last, out_cut;
    logic        busy, cut_topo_err, el_vb_sel;
    logic [5:0]  cmd_topo;
    logic [1:0]  ib_width;
    logic [2:0]  el_ncomp;
    logic [7:0]  el_src;
    logic [31:0] cmd_start, cmd_vcount, cmd_icount, mem_addr, mem_rdata, out_data, el_offset;
    logic [`VFX_NVB-1:0][31:0] vb_base, vb_stride, vb_limit, vb_last;
    logic [`VFX_NVB-1:0]       vb_inst;
    logic [33:0] q[$];
    int          fail_count, compares;
    vfx_row_t    r;
    // index reads stay inside the list row 6 sends a topology without cut support
    vfx_row_t    rows[8] = '{
        '{0, 0, 0, 0, 6'h04, 2'b00, 2, 3, 2, 4, 8'he4},
        '{0, 0, 1, 0, 6'h05, 2'b00, 0, 2, 3, 2, 8'h00},
        '{0, 0, 0, 0, 6'h03, 2'b00, 4, 3, 1, 4, 8'h00},
        '{1, 1, 0, 0, 6'h05, 2'b00, 24, 8, 1, 3, 8'h20},
        '{1, 1, 0, 0, 6'h20, 2'b01, 12, 4, 1, 1, 8'h00},
        '{1, 0, 0, 0, 6'h01, 2'b10, 5, 3, 2, 2, 8'h0c},
        '{1, 1, 0, 1, 6'h07, 2'b00, 0, 1, 1, 1, 8'h00},
        '{0, 0, 0, 0, 6'h04, 2'b00, 0, 0, 1, 1, 8'h00}
    };
    vfx_fetch vfx_fetch_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_random(cmd_random), .cmd_topo(cmd_topo), .cmd_start(cmd_start),
        .cmd_vcount(cmd_vcount), .cmd_icount(cmd_icount), .ib_base(32'h0000_1000),
        .ib_width(ib_width), .ib_cut_en(ib_cut_en), .vb_base(vb_base), .vb_stride(vb_stride),
        .vb_inst(vb_inst), .vb_limit(vb_limit), .vb_last(vb_last), .el_load(el_load),
        .el_vb_sel(el_vb_sel), .el_offset(el_offset), .el_ncomp(el_ncomp), .el_src(el_src),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_last(out_last), .out_cut(out_cut), .busy(busy),
        .cut_topo_err(cut_topo_err)
    );
    vfx_mem_model vfx_mem_model_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
    );
    function automatic logic [31:0] memw(input logic [31:0] a);
        if (a[31:6] == 26'h000_0040)
            return (a[5:2] == 4'h7) ? 32'hffff_ffff : {28'h000_0000, a[5:2]};
        return a ^ 32'ha5a5_0000;
    endfunction
    function automatic logic [31:0] msk(input logic [1:0] w);
        return (w == `VFX_IW8) ? `VFX_MSK8 : (w == `VFX_IW16) ? `VFX_MSK16 : `VFX_MSK32;
    endfunction
    // entries zero-extended to a full word
    function automatic logic [31:0] entry(input int k, input logic [1:0] w);
        int b;
        b = (w == `VFX_IW8) ? k : (w == `VFX_IW16) ? 2 * k : 4 * k;
        return (memw(32'h0000_1000 + 32'(b & ~3)) >> (8 * (b % 4))) & msk(w);
    endfunction
    function automatic bit topo_ok(input logic [5:0] t);
        return (t >= `VFX_T_POINTLIST && t <= `VFX_T_TRISTRIP_RV) || t >= `VFX_T_PATCH_LO
            || (t >= `VFX_T_LINELIST_A && t <= `VFX_T_TRISTRIP_A)
            || (t >= `VFX_T_POINT_BF && t <= `VFX_T_LSTRIP_CBF);
    endfunction
    function automatic logic [31:0] val(vfx_row_t r, logic [31:0] n, vid, int i, c);
        logic [31:0] x;
        logic [31:0] a;
        x = vb_inst[r.sel] ? 32'(i) : n;
        a = vb_base[r.sel] + x * vb_stride[r.sel] + 32'(4 * (c + r.sel));
        case (r.src[2*c+:2])
            `VFX_SRC_ZERO: return `VFX_ZERO32;
            `VFX_SRC_VID: return vid;
            `VFX_SRC_IID: return 32'(i);
            default: return (vb_inst[r.sel] || r.rnd)
                ? ((x > vb_limit[r.sel]) ? `VFX_ZERO32 : memw(a))
                : ((a + 32'h0000_0003 > vb_last[r.sel]) ? `VFX_ZERO32 : memw(a));
        endcase
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // abort leaves the draw running, for the mid-draw reset
    task automatic run(input vfx_row_t r, input bit abort);
        logic [31:0] e;
        int          k;
        int          errs;
        int          nc;
        for (k = 0; k < 200; k++) begin
            @(posedge clk_sys);
            if (cmd_ready === 1'b1)
                break;
        end
        if (k == 200) begin
            fail_count++;
            results();
        end
        // buffer 1 elements sit one word into the structure
        el_offset <= 32'(4 * r.sel);
        {el_load, el_vb_sel, el_ncomp, el_src} <= {1'b1, r.sel, r.nc[2:0], r.src};
        {cmd_random, cmd_topo, ib_width, ib_cut_en} <= {r.rnd, r.topo, r.w, r.cut};
        {cmd_start, cmd_vcount, cmd_icount} <= {r.start, r.vc, r.ic};
        @(posedge clk_sys);
        el_load <= 1'b0;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        if (abort)
            return;
        q = {};
        nc = (r.nc > `VFX_NCOMP_MAX) ? `VFX_NCOMP_MAX : r.nc;
        for (int i = 0; i < r.ic && !r.err; i++) begin
            for (int v = 0; v < r.vc; v++) begin
                e = entry(r.start + v, r.w);
                if (r.rnd && r.cut && e == msk(r.w))
                    q.push_back({2'b11, `VFX_ZERO32});
                else for (int c = 0; c < nc; c++)
                    q.push_back({1'b0, c == nc - 1,
                        val(r, r.rnd ? e : 32'(r.start + v), r.rnd ? e : 32'(v), i, c)});
            end
        end
        errs = 0;
        // 21-cycle early stall, too short for the fifo to fill and hold back the fetch
        for (k = 0; k < 3000; k++) begin
            @(posedge clk_sys);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                e = 32'(q.size());
                chk({out_cut, out_last, out_data},
                    (e > 0) ? q.pop_front() : '1);
            end
            errs += (cut_topo_err === 1'b1) ? 1 : 0;
            out_ready <= (k > 20) && (k % 5 != 4);
            if (k > 6 && q.size() == 0 && busy === 1'b0 && out_valid === 1'b0)
                break;
        end
        if (k == 3000) begin
            fail_count++;
            results();
        end
        chk(34'(errs), 34'(r.err));
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        fail_count = 0;
        compares = 0;
        rst_b = 1'b0;
        {cmd_valid, cmd_random, ib_cut_en, el_load, slow, out_ready, el_vb_sel} = 7'h00;
        {cmd_topo, ib_width, el_ncomp, el_src, cmd_start, cmd_vcount, cmd_icount} = '0;
        vb_base = {32'h0000_4000, 32'h0000_2000};
        vb_stride = {32'h0000_0004, 32'h0000_0010};
        vb_limit = {32'h0000_0001, 32'h0000_0006};
        vb_last = {32'h0000_4fff, 32'h0000_205b};
        vb_inst = 2'b10;
        repeat (5) @(posedge clk_sys);
        chk({30'h0000_0000, cmd_ready, busy, mem_req, out_valid}, 34'h0_0000_0000);
        rst_b <= 1'b1;
        foreach (rows[j]) begin
            slow <= j[0];
            run(rows[j], 1'b0);
            $display("row %0d done", j);
        end
        slow <= 1'b0;
        for (int t = 0; t < 64; t++) begin
            // seven components asked for, four expected back
            r = '{1, 1, 0, !topo_ok(6'(t)), 6'(t), 2'b00, 0, 1, 1, 7, 8'h01};
            run(r, 1'b0);
        end
        $display("topology sweep done");
        run(rows[0], 1'b1);
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({30'h0000_0000, cmd_ready, busy, mem_req, out_valid}, 34'h0_0000_0000);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        run(rows[2], 1'b0);
        $display("mid-draw reset done");
        results();
    end
endmodule // vertex_fetch_index_buffer_access_tb_top
